// ---- rtl/sah_params.svh ----
// Constants of the host-port and conversion sequencer.
// Included by every design file that needs them; the package does not include it.
`ifndef SAH_PARAMS_SVH
`define SAH_PARAMS_SVH

// Setup byte field positions
`define SAH_F_CHAN_HI   4
`define SAH_F_CHAN_LO   0
`define SAH_F_UNSIGNED  5
`define SAH_F_RES8      6
`define SAH_F_LEFT      7
`define SAH_SETUP_RST   8'h00

// Half-rate periods of acquisition
`define SAH_ACQ_HALF    4'h3

// Half-rate cycles of conversion per resolution
`define SAH_CONV_8      4'h8
`define SAH_CONV_8S     4'h9
`define SAH_CONV_10     4'hA
`define SAH_CONV_10S    4'hB

// Result word and buffer
`define SAH_WORD_W      16
`define SAH_FIFO_DEPTH  8
`define SAH_WORD_BITS   5'h10

// Trial bit of the first magnitude decision
`define SAH_MSB_TRIAL   10'h200

// Common channel of pseudo-differential mode
`define SAH_PSEUDO_COM  3'h7

`endif

// ---- rtl/sah_pkg.sv ----
// Types of the host-port and conversion sequencer.
// Assumes sah_params.svh is on the include path.
package sah_pkg;

  typedef enum logic [1:0] {SAH_MUX_DIFF, SAH_MUX_SINGLE, SAH_MUX_PSEUDO} sah_mux_mode_type;

  typedef enum logic [1:0] {SAH_IDLE, SAH_ACQ, SAH_CONV, SAH_STORE} sah_seq_type;

  // Setup byte, bit 7 down to bit 0
  typedef struct packed {
    logic       left_just;
    logic       res_8;
    logic       unsgn;
    logic [4:0] chan_addr;
  } sah_setup_type;

  typedef struct packed {
    sah_mux_mode_type mode;
    logic [2:0]       pos;
    logic [2:0]       neg;
  } sah_mux_sel_type;

  // Strobes, active high after inversion
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
  } sah_strobe_type;

  typedef struct packed {
    sah_strobe_type  s1;
    sah_strobe_type  s2;
    logic [7:0]      db1;
    logic [7:0]      db2;
    logic            wr_act_d;
    logic            rd_act_d;
    logic            wr_rd;
    sah_setup_type   stage;
    sah_setup_type   setup;
    sah_setup_type   conv_setup;
    sah_mux_sel_type mux;
    logic            req;
    logic            div;
    sah_seq_type     seq;
    logic [3:0]      hcnt;
    logic [3:0]      step;
    logic [9:0]      code;
    logic [9:0]      trial;
    logic [9:0]      dac;
    logic            sign;
    logic            in_neg;
    logic [15:0]     out_word;
    logic            out_full;
    logic            byte2;
    logic            done;
    logic [7:0]      db_out;
  } sah_top_state_type;

endpackage

// ---- rtl/sah_sequencer.sv ----
// Host port, conversion sequencer and result buffer of a APPROXIMATION_REGISTER converter.
// Assumes host strobes and data arrive asynchronously; comparator inputs
// come from logic on i_core_clk.
// Behaviour
// - CS and WR low together capture the bus byte as the setup word.
// - Setup bits 0 to 4 form the five-bit channel address.
// - Setup bit 5 selects unsigned or signed results.
// - Setup bit 6 selects 8-bit or 10-bit resolution.
// - Setup bit 7 selects left or right justification.
// - Rising write strobe sets the conversion request flag.
// - Acquisition starts at the next half-rate clock falling edge after request.
// - Acquisition lasts three half-rate periods, six device clocks.
// - Input is held and conversion begins right after acquisition.
// - Conversion takes 8, 9, 10 or 11 half-rate cycles per resolution.
// - A request in the rising half-rate phase adds one device clock.
// - Done is asserted only on a half-rate falling edge.
// - Done goes low when a result is available.
// - First read drives byte one; read falling edge returns done high.
// - Second read drives byte two.
// - A new request is accepted before the second byte is read.
// - CS, WR and RD all low start a conversion keeping setup.
// - Host accesses need no relation to the device clock.
// - Request is set by whichever ends the write first, WR or CS.
// - Raw result is formatted to resolution, sign mode and justification.
// - Unsigned mode with positive input below negative gives zero.
// - Channel address selects differential, single-ended or pseudo-differential.
`include "sah_params.svh"
`timescale 1ns/100ps
`default_nettype none

module sah_fifo
#(
  parameter int W = `SAH_WORD_W,
  parameter int D = `SAH_FIFO_DEPTH
)
(
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } sah_fifo_state_type;

  sah_fifo_state_type st_r;
  sah_fifo_state_type st_nxt;
  logic               push;
  logic               pop;

  // Full when the count reaches the depth
  assign o_in_ready  = (st_r.cnt != (AW+1)'(D));
  assign o_out_valid = (st_r.cnt != '0);
  assign o_out_data  = st_r.mem[st_r.rp];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wp] = i_in_data;
      st_nxt.wp           = st_r.wp + AW'(1);
    end
    if (pop)
    begin
      st_nxt.rp = st_r.rp + AW'(1);
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule

module sah_sequencer
(
  input  wire logic                    i_core_clk,
  input  wire logic                    i_arst_n,
  input  wire logic                    i_cs_n,
  input  wire logic                    i_wr_n,
  input  wire logic                    i_rd_n,
  input  wire logic [7:0]              i_db_in,
  input  wire logic                    i_cmp_bit,
  input  wire logic                    i_in_neg,
  output logic [7:0]                   o_db_out,
  output logic                         o_db_oe_n,
  output logic                         o_int_n,
  output var sah_pkg::sah_mux_sel_type o_mux_sel,
  output logic                         o_track,
  output logic                         o_hold,
  output logic [9:0]                   o_dac_code,
  output logic                         o_half_clk
);
  import sah_pkg::*;

  sah_top_state_type st_r;
  sah_top_state_type nx;
  logic              wr_act;
  logic              rd_act;
  logic              wr_end;
  logic              fall;
  logic [3:0]        nsteps;
  logic [15:0]       rj_word;
  logic [15:0]       fmt_word;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [15:0]       fifo_out_data;

  function automatic logic [3:0] conv_steps(input sah_setup_type s);
    logic [3:0] n;
    n = `SAH_CONV_10S;
    unique case ({s.res_8, s.unsgn})
      2'b11: n = `SAH_CONV_8;
      2'b10: n = `SAH_CONV_8S;
      2'b01: n = `SAH_CONV_10;
      2'b00: n = `SAH_CONV_10S;
    endcase
    return n;
  endfunction

  function automatic sah_mux_sel_type mux_decode(input logic [4:0] a);
    sah_mux_sel_type m;
    m.mode = SAH_MUX_DIFF;
    m.pos  = a[2:0];
    m.neg  = {a[2:1], ~a[0]};
    if (a[3] && a[4])
    begin
      m.mode = SAH_MUX_PSEUDO;
      m.neg  = `SAH_PSEUDO_COM;
    end
    else if (a[3])
    begin
      m.mode = SAH_MUX_SINGLE;
      m.neg  = 3'h0;
    end
    return m;
  endfunction

  assign wr_act = st_r.s2.sel & st_r.s2.wr;
  assign rd_act = st_r.s2.sel & st_r.s2.rd;
  // Write ends when WR or CS rises, as seen after sync
  assign wr_end = st_r.wr_act_d & ~wr_act;
  assign fall   = st_r.div;
  assign nsteps = conv_steps(st_r.conv_setup);

  always_comb
  begin
    rj_word = {6'h00, st_r.code};
    // Signed results carry sign bits above the magnitude
    unique case ({st_r.conv_setup.res_8, st_r.conv_setup.unsgn})
      2'b11: rj_word = {8'h00, st_r.code[9:2]};
      2'b10: rj_word = {{8{st_r.sign}}, st_r.code[9:2]};
      2'b01: rj_word = {6'h00, st_r.code};
      2'b00: rj_word = {{6{st_r.sign}}, st_r.code};
    endcase
    if (st_r.conv_setup.unsgn && st_r.in_neg)
    begin
      rj_word = 16'h0000;
    end
    // Left justification puts the top result bit at bit 15
    fmt_word = rj_word;
    if (st_r.conv_setup.left_just)
    begin
      fmt_word = rj_word << (`SAH_WORD_BITS - {1'b0, nsteps});
    end
  end

  assign fifo_out_ready = fall & ~st_r.out_full;

  sah_fifo
  #(
    .W (`SAH_WORD_W),
    .D (`SAH_FIFO_DEPTH)
  )
  u_fifo
  (
    .i_core_clk  (i_core_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (st_r.seq == SAH_STORE),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fmt_word),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  always_comb
  begin
    nx = st_r;
    // Two-stage synchronisers for host pins
    nx.s1       = {~i_cs_n, ~i_wr_n, ~i_rd_n};
    nx.s2       = st_r.s1;
    nx.db1      = i_db_in;
    nx.db2      = st_r.db1;
    nx.wr_act_d = wr_act;
    nx.rd_act_d = rd_act;

    // Setup capture
    if (wr_act)
    begin
      if (rd_act)
      begin
        nx.wr_rd = 1'b1;
      end
      else if (!st_r.wr_rd)
      begin
        nx.stage = sah_setup_type'(st_r.db2);
      end
    end
    if (wr_end)
    begin
      if (!st_r.wr_rd)
      begin
        nx.setup = st_r.stage;
      end
      nx.wr_rd = 1'b0;
    end
    nx.mux = mux_decode(st_r.setup.chan_addr);

    // Half-rate divider
    nx.div = ~st_r.div;

    // Sequencer
    unique case (st_r.seq)
      SAH_IDLE:
      begin
        if (fall && st_r.req)
        begin
          nx.seq        = SAH_ACQ;
          nx.hcnt       = 4'h0;
          nx.req        = 1'b0;
          nx.conv_setup = st_r.setup;
        end
      end
      SAH_ACQ:
      begin
        if (fall)
        begin
          nx.hcnt = st_r.hcnt + 4'h1;
          if (st_r.hcnt == `SAH_ACQ_HALF - 4'h1)
          begin
            nx.seq    = SAH_CONV;
            nx.step   = 4'h0;
            nx.code   = 10'h000;
            // Signed runs spend the first decision on the sign
            nx.trial  = 10'h000;
            if (st_r.conv_setup.unsgn)
            begin
              nx.trial = `SAH_MSB_TRIAL;
            end
            nx.sign   = 1'b0;
            nx.in_neg = i_in_neg;
          end
        end
      end
      SAH_CONV:
      begin
        if (fall)
        begin
          nx.step = st_r.step + 4'h1;
          if (st_r.trial == 10'h000)
          begin
            nx.sign  = i_cmp_bit;
            nx.trial = `SAH_MSB_TRIAL;
          end
          else
          begin
            nx.code  = st_r.code | (i_cmp_bit ? st_r.trial : 10'h000);
            nx.trial = st_r.trial >> 1;
          end
          if (st_r.step == nsteps - 4'h1)
          begin
            nx.seq = SAH_STORE;
          end
        end
      end
      SAH_STORE:
      begin
        // Waits here while the buffer is full
        if (fifo_in_ready)
        begin
          nx.seq = SAH_IDLE;
        end
      end
    endcase
    nx.dac = nx.code | nx.trial;

    // Request set wins over the clear above
    if (wr_end)
    begin
      nx.req = 1'b1;
    end

    // Result output stage
    if (rd_act && !st_r.rd_act_d)
    begin
      nx.done = 1'b0;
    end
    if (!rd_act && st_r.rd_act_d && st_r.out_full)
    begin
      nx.byte2 = ~st_r.byte2;
      if (st_r.byte2)
      begin
        nx.out_full = 1'b0;
      end
    end
    if (fifo_out_ready && fifo_out_valid)
    begin
      nx.out_word = fifo_out_data;
      nx.out_full = 1'b1;
      nx.byte2    = 1'b0;
      nx.done     = 1'b1;
    end
    // Byte one is the high half, byte two the low half
    nx.db_out = nx.out_word[15:8];
    if (nx.byte2)
    begin
      nx.db_out = nx.out_word[7:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= nx;
    end
  end

  // Status and phase outputs
  assign o_db_out   = st_r.db_out;
  assign o_db_oe_n  = ~rd_act;
  assign o_int_n    = ~st_r.done;
  assign o_mux_sel  = st_r.mux;
  assign o_track    = (st_r.seq == SAH_ACQ);
  assign o_hold     = (st_r.seq == SAH_CONV);
  assign o_dac_code = st_r.dac;
  assign o_half_clk = st_r.div;

endmodule

`default_nettype wire

// ---- dv/sah_sequencer_sva.sv ----
// Checker of host port and conversion timing of sah_sequencer.
// Bound to sah_sequencer; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module sah_sequencer_sva
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic o_db_oe_n,
  input wire logic o_int_n,
  input wire logic o_track,
  input wire logic o_hold,
  input wire logic o_half_clk
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_acq;
    o_track [*6] ##1 !o_track;
  endsequence
  sequence s_conv;
    o_hold [*8] ##1 o_hold [*8] ##[1:7] !o_hold;
  endsequence
  property p_oe;
    !o_db_oe_n |-> !$past(i_cs_n, 2) && !$past(i_rd_n, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven off read");
  property p_acq;
    $rose(o_track) |-> s_acq;
  endproperty
  a_acq: assert property (p_acq) else $error("track length");
  property p_start;
    $rose(o_track) |-> $fell(o_half_clk);
  endproperty
  a_start: assert property (p_start) else $error("track off half fall");
  property p_conv;
    $fell(o_track) |-> s_conv;
  endproperty
  a_conv: assert property (p_conv) else $error("hold not after track");
  property p_excl;
    !(o_track && o_hold);
  endproperty
  a_excl: assert property (p_excl) else $error("track and hold");
  property p_int;
    $fell(o_int_n) |-> $fell(o_half_clk);
  endproperty
  a_int: assert property (p_int) else $error("done off half fall");
  property p_div;
    $changed(o_half_clk) |=> $changed(o_half_clk);
  endproperty
  a_div: assert property (p_div) else $error("half clock stuck");
  property p_clr;
    !i_cs_n && !i_rd_n && !o_int_n |-> ##[1:4] o_int_n;
  endproperty
  a_clr: assert property (p_clr) else $error("done not cleared");
endmodule
bind sah_sequencer sah_sequencer_sva i_sah_sequencer_sva (.i_core_clk, .i_arst_n, .i_cs_n,
  .i_rd_n, .o_db_oe_n, .o_int_n, .o_track, .o_hold, .o_half_clk);
`default_nettype wire

// ---- dv/sah_host_model.sv ----
// Host processor on the parallel strobe bus.
// Drives pins after rising edges; write strobes held 4 clocks each way, read strobes low 5 clocks and high 4.
`timescale 1ns/100ps
`default_nettype none
module sah_host_model
(
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_db_out,
  output logic            o_cs_n,
  output logic            o_wr_n,
  output logic            o_rd_n,
  output logic [7:0]      o_db
);
  initial
  begin
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_db   = 8'hA5;
  end
  // Write; all3 keeps RD low too; cs_first ends it by CS, else by WR with CS kept low
  // Returns when both strobes rise, before the conversion starts
  task automatic write_byte(input logic [7:0] d, input logic all3, input logic cs_first);
    @(posedge i_core_clk);
    o_cs_n <= 1'b0;
    o_wr_n <= 1'b0;
    o_rd_n <= !all3;
    o_db   <= d;
    repeat (4) @(posedge i_core_clk);
    o_cs_n <= cs_first;
    o_wr_n <= !cs_first;
    o_rd_n <= 1'b1;
    o_db   <= ~d;
    repeat (4) @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    o_wr_n <= 1'b1;
  endtask
  task automatic read_byte(output logic [7:0] d);
    @(posedge i_core_clk);
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk);
    d = i_db_out;
    @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// ---- dv/sah_sequencer_tb.sv ----
// Testbench of sah_sequencer: setup writes, timing and result reads.
// Comparator is a fixed threshold on the trial code.
`timescale 1ns/100ps
`default_nettype none
module sah_sequencer_tb;
  import sah_pkg::*;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            in_neg = 1'b1;
  wire             cs_n, wr_n, rd_n, oe_n, int_n, track, hold, half;
  wire [7:0]       db_in, db_out;
  wire [9:0]       dac;
  wire             cmp = (dac <= 10'h155);
  sah_mux_sel_type mux;
  int              fail_count = 0;
  int              compares = 0;
  int              nt, nh, i;
  logic [7:0]      b, st, prev;
  logic [7:0]      tbl [8] = '{8'h60, 8'h41, 8'h2B, 8'h97, 8'hF8, 8'h1E, 8'hA6, 8'hCD};
  // Expected words: code 155h, sign set, unsigned zero when in_neg is high
  logic [15:0]     tbw [8] = '{16'h0055, 16'hFF55, 16'h0000, 16'hAAA0,
                               16'h5500, 16'hFD55, 16'h0000, 16'hAA80};
  always #2 clk = ~clk;
  sah_host_model i_sah_host_model (.i_core_clk(clk), .i_db_out(db_out), .o_cs_n(cs_n),
    .o_wr_n(wr_n), .o_rd_n(rd_n), .o_db(db_in));
  sah_sequencer i_sah_sequencer (.i_core_clk(clk), .i_arst_n(rst_n), .i_cs_n(cs_n),
    .i_wr_n(wr_n), .i_rd_n(rd_n), .i_db_in(db_in), .i_cmp_bit(cmp), .i_in_neg(in_neg),
    .o_db_out(db_out), .o_db_oe_n(oe_n), .o_int_n(int_n), .o_mux_sel(mux),
    .o_track(track), .o_hold(hold), .o_dac_code(dac), .o_half_clk(half));
  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timeout;
    fail_count++;
    $display("MISMATCH %0t wait ran out", $time);
    print_verdict;
  endtask
  function automatic sah_mux_sel_type exp_mux(input logic [4:0] c);
    if (!c[3])
      return sah_mux_sel_type'{SAH_MUX_DIFF, c[2:0], c[2:0] ^ 3'h1};
    if (c[4])
      return sah_mux_sel_type'{SAH_MUX_PSEUDO, c[2:0], 3'h7};
    return sah_mux_sel_type'{SAH_MUX_SINGLE, c[2:0], 3'h0};
  endfunction
  function automatic int conv_len(input logic [7:0] s);
    return s[6] ? (s[5] ? 8 : 9) : (s[5] ? 10 : 11);
  endfunction
  task automatic run_conv;
    int k;
    k = 0;
    nt = 0;
    nh = 0;
    while (track !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 40)
      timeout;
    while (track === 1'b1 && nt < 64)
    begin
      @(negedge clk);
      nt++;
    end
    while (hold === 1'b1 && nh < 64)
    begin
      @(negedge clk);
      nh++;
    end
  endtask
  task automatic wait_int;
    int k;
    k = 0;
    while (int_n !== 1'b0 && k < 60)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 60)
      timeout;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    check({int_n, oe_n, track, hold, half, mux}, 13'h1800);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 8; i++)
    begin
      st = tbl[i];
      in_neg <= i[1];
      i_sah_host_model.write_byte(st, 1'b0, i[0]);
      run_conv;
      check(nt, 6);
      check(nh, 2 * conv_len(st));
      check(mux, exp_mux(st[4:0]));
      if (i > 0)
      begin
        i_sah_host_model.read_byte(b);
        check(b, tbw[i-1][7:0]);
      end
      wait_int;
      i_sah_host_model.read_byte(b);
      check(int_n, 1'b1);
      check(b, tbw[i][15:8]);
      prev = st;
    end
    i_sah_host_model.read_byte(b);
    check(b, tbw[7][7:0]);
    i_sah_host_model.write_byte(8'h2B, 1'b1, 1'b0);
    run_conv;
    check(nh, 2 * conv_len(prev));
    check(mux, exp_mux(prev[4:0]));
    wait_int;
    i_sah_host_model.read_byte(b);
    check(b, tbw[7][15:8]);
    i_sah_host_model.read_byte(b);
    check(b, tbw[7][7:0]);
    check(oe_n, 1'b1);
    print_verdict;
  end
endmodule
`default_nettype wire
